// ==== design/vcc_config_bank.sv ====
// Notes on behaviour
// - capability identifier byte at a4h always reads 09h.
// - next-capability pointer at a4h bits 15:8 reads e0h.
// - length field at a4h bits 31:16 reads 28h.
// - test words at a8h and ach are full read-write with fixed reset values.
// - replay timeout value, 12 bits at b0h 11:0, resets to zero.
// - bit 12 set makes the link use the user replay timeout.
// - ack latency value, 14 bits at b0h 29:16, resets to zero.
// - bit 30 set makes the link use user ack latency; bit 31 reads zero.
// - timer, driver, power and strap fields accept autoloaded defaults.
// - port zero driver mode at b4h 3:0, four codes, resets to zero.
// - port one driver mode at b4h 7:4; bits 31:8 plain read-write.
// - power parameter at b8h 5:0 read-write; upper bits read zero.
// - debug words at bch, c0h, c4h are read-only zero.
// - c8h bit 0 shows low-drive strap, bit 1 high-drive strap.
// - c8h bits 5:2 transmit-current straps, bits 9:6 de-emphasis straps.
// - c8h bits 11:10 rx, 13:12 tx termination straps; rest zero.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "vcc_defs.svh"
module vcc_config_bank
	import vcc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// non-volatile autoload
	input wire logic nvLoadValid,
	input wire logic [7:0] nvLoadAddress,
	input wire logic [31:0] nvLoadData,
	// strap pins
	input wire logic lowDriveStrap,
	input wire logic highDriveStrap,
	input wire logic [3:0] transmitCurrentStraps,
	input wire logic [3:0] deemphasisStraps,
	input wire logic [1:0] rxTerminationStraps,
	input wire logic [1:0] txTerminationStraps,
	// link layer timers
	input wire logic [11:0] builtinReplayTimeout,
	input wire logic [13:0] builtinAckLatency,
	output logic [11:0] replayTimeout,
	output logic [13:0] ackLatency,
	// serial port and power settings
	output logic [3:0] driverMode0,
	output logic [3:0] driverMode1,
	output vcc_drv_kind_t driverKind0,
	output vcc_drv_kind_t driverKind1,
	output logic [5:0] powerParameter,
	output logic strapsValid
);
	// -----------------------------------------------------------------
	// state and helpers
	// -----------------------------------------------------------------
	vcc_state_t st_q;
	vcc_state_t st_d;
	logic [13:0] strapSync;
	logic strapAgree;
	vcc_drv_kind_t kind0;
	vcc_drv_kind_t kind1;
	logic busReq;
	logic busTake;
	logic busWr;
	logic [31:0] capWord;
	logic [31:0] tmrWord;
	logic [31:0] pmWord;
	logic [31:0] strapWord;
	logic [31:0] rdVal;
	logic [31:0] tmrNew;
	logic [31:0] pmNew;

	// only the enabled byte lanes change
	function automatic logic [31:0] beMerge(input logic [31:0] old,
		input logic [31:0] wdat, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[i*8 +: 8] = wdat[i*8 +: 8];
		end
		return res;
	endfunction : beMerge

	// -----------------------------------------------------------------
	// submodules
	// -----------------------------------------------------------------
	// strap order inside the vector is the reflected bit order
	vcc_sync3 #(
		.WIDTH(14)
	) u_strapSync (
		.clk(clk),
		.reset_n(reset_n),
		.asyncIn({txTerminationStraps, rxTerminationStraps, deemphasisStraps,
			transmitCurrentStraps, highDriveStrap, lowDriveStrap}),
		.syncOut(strapSync),
		.agree(strapAgree)
	);

	vcc_drv_decode u_drvDecode0 (
		.code(st_q.drv[`VCC_F_DRV0]),
		.kind(kind0),
		.legal()
	);

	vcc_drv_decode u_drvDecode1 (
		.code(st_q.drv[`VCC_F_DRV1]),
		.kind(kind1),
		.legal()
	);

	// -----------------------------------------------------------------
	// read views
	// -----------------------------------------------------------------
	// packed words; unlisted bits stay zero so read-only bits read zero
	always_comb
	begin
		capWord = `VCC_ZERO32;
		capWord[`VCC_F_ID] = `VCC_CAP_ID;
		capWord[`VCC_F_NEXT] = `VCC_CAP_NEXT;
		capWord[`VCC_F_LEN] = `VCC_CAP_LEN;
		tmrWord = `VCC_ZERO32;
		tmrWord[`VCC_F_RPL] = st_q.rpl;
		tmrWord[`VCC_B_RPLEN] = st_q.rplEn;
		tmrWord[`VCC_F_ACK] = st_q.ackLat;
		tmrWord[`VCC_B_ACKEN] = st_q.ackEn;
		pmWord = `VCC_ZERO32;
		pmWord[`VCC_F_PM] = st_q.pm;
		strapWord = `VCC_ZERO32;
		strapWord[`VCC_F_STRAP] = st_q.strap;
	end

	// address decode; unmapped and debug offsets read zero
	always_comb
	begin
		if (avs_address == `VCC_OFS_CAP)
			rdVal = capWord;
		else if (avs_address == `VCC_OFS_TST0)
			rdVal = st_q.test0;
		else if (avs_address == `VCC_OFS_TST1)
			rdVal = st_q.test1;
		else if (avs_address == `VCC_OFS_TMR)
			rdVal = tmrWord;
		else if (avs_address == `VCC_OFS_DRV)
			rdVal = st_q.drv;
		else if (avs_address == `VCC_OFS_PM)
			rdVal = pmWord;
		else if (avs_address == `VCC_OFS_STRAP)
			rdVal = strapWord;
		else
			rdVal = `VCC_ZERO32;
	end

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	// one wait cycle: data latched at the first edge, taken at the second
	assign busReq = avs_read | avs_write;
	assign busTake = busReq & ~st_q.ack;
	assign busWr = avs_write & st_q.ack;
	assign tmrNew = beMerge(tmrWord, avs_writedata, avs_byteenable);
	assign pmNew = beMerge(pmWord, avs_writedata, avs_byteenable); // only lane zero holds storage

	always_comb
	begin
		st_d = st_q;
		st_d.ack = busTake;
		if (busTake)
			st_d.rdata = avs_read ? rdVal : `VCC_ZERO32;

		// one-time strap capture once the chain has filled and settled
		if (!st_q.strapDone)
		begin
			if (st_q.settle != `VCC_SETTLE)
				st_d.settle = st_q.settle + 2'h1;
			else if (strapAgree)
			begin
				st_d.strap = strapSync;
				st_d.strapDone = 1'b1;
			end
		end

		// autoload overrides defaults and any captured strap value
		if (nvLoadValid)
		begin
			if (nvLoadAddress == `VCC_OFS_TMR)
			begin
				st_d.rpl = nvLoadData[`VCC_F_RPL];
				st_d.rplEn = nvLoadData[`VCC_B_RPLEN];
				st_d.ackLat = nvLoadData[`VCC_F_ACK];
				st_d.ackEn = nvLoadData[`VCC_B_ACKEN];
			end
			else if (nvLoadAddress == `VCC_OFS_DRV)
				st_d.drv = nvLoadData;
			else if (nvLoadAddress == `VCC_OFS_PM)
				st_d.pm = nvLoadData[`VCC_F_PM];
			else if (nvLoadAddress == `VCC_OFS_STRAP)
			begin
				st_d.strap = nvLoadData[`VCC_F_STRAP];
				st_d.strapDone = 1'b1;
			end
		end

		// software write lands last so it wins a same-cycle autoload
		if (busWr)
		begin
			if (avs_address == `VCC_OFS_TST0)
				st_d.test0 = beMerge(st_q.test0, avs_writedata, avs_byteenable);
			else if (avs_address == `VCC_OFS_TST1)
				st_d.test1 = beMerge(st_q.test1, avs_writedata, avs_byteenable);
			else if (avs_address == `VCC_OFS_TMR)
			begin
				st_d.rpl = tmrNew[`VCC_F_RPL];
				st_d.rplEn = tmrNew[`VCC_B_RPLEN];
				st_d.ackLat = tmrNew[`VCC_F_ACK];
				st_d.ackEn = tmrNew[`VCC_B_ACKEN];
			end
			else if (avs_address == `VCC_OFS_DRV)
				st_d.drv = beMerge(st_q.drv, avs_writedata, avs_byteenable);
			else if (avs_address == `VCC_OFS_PM)
				st_d.pm = pmNew[`VCC_F_PM];
			// other offsets are read-only; writes fall through
		end

		// link layer picks user or built-in timer values
		st_d.effRpl = st_q.rplEn ? st_q.rpl : builtinReplayTimeout;
		st_d.effAck = st_q.ackEn ? st_q.ackLat : builtinAckLatency;
		st_d.kind0 = kind0;
		st_d.kind1 = kind1;
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q <= '0;
			st_q.test0 <= `VCC_TST0_RST;
			st_q.test1 <= `VCC_TST1_RST;
			st_q.rpl <= `VCC_RPL_RST;
			st_q.ackLat <= `VCC_ACK_RST;
			st_q.drv <= `VCC_DRV_RST;
			st_q.pm <= `VCC_PM_RST;
			st_q.strap <= `VCC_STRAP_RST;
			st_q.kind0 <= VCC_KIND_SINGLE;
			st_q.kind1 <= VCC_KIND_SINGLE;
		end
		else
			st_q <= st_d;
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign avs_waitrequest = busReq & ~st_q.ack;
	assign avs_readdata = st_q.rdata;
	assign replayTimeout = st_q.effRpl;
	assign ackLatency = st_q.effAck;
	assign driverMode0 = st_q.drv[`VCC_F_DRV0];
	assign driverMode1 = st_q.drv[`VCC_F_DRV1];
	assign driverKind0 = st_q.kind0;
	assign driverKind1 = st_q.kind1;
	assign powerParameter = st_q.pm;
	assign strapsValid = st_q.strapDone;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_wait_bound: assert property (busReq |-> ##[0:1] !avs_waitrequest)
		else $error("waitrequest held too long");
	a_cap_id_read: assert property (st_q.ack && avs_read && avs_address == `VCC_OFS_CAP
		|-> avs_readdata[`VCC_F_ID] == `VCC_CAP_ID)
		else $error("capability id wrong");
	a_cap_next_read: assert property (st_q.ack && avs_read && avs_address == `VCC_OFS_CAP
		|-> avs_readdata[`VCC_F_NEXT] == `VCC_CAP_NEXT)
		else $error("next pointer wrong");
	a_cap_len_read: assert property (st_q.ack && avs_read && avs_address == `VCC_OFS_CAP
		|-> avs_readdata[`VCC_F_LEN] == `VCC_CAP_LEN)
		else $error("length wrong");
	a_test_word_write: assert property (st_q.ack && avs_write && avs_address == `VCC_OFS_TST0
		&& avs_byteenable == `VCC_BE_ALL |=> st_q.test0 == $past(avs_writedata))
		else $error("test word not written");
	a_byte_none_kept: assert property (st_q.ack && avs_write && avs_address == `VCC_OFS_TST1
		&& avs_byteenable == `VCC_BE_NONE |=> $stable(st_q.test1))
		else $error("disabled lanes changed");
	a_replay_select: assert property (reset_n |=> replayTimeout ==
		($past(st_q.rplEn) ? $past(st_q.rpl) : $past(builtinReplayTimeout)))
		else $error("replay timeout source wrong");
	a_ack_select: assert property (reset_n |=> ackLatency ==
		($past(st_q.ackEn) ? $past(st_q.ackLat) : $past(builtinAckLatency)))
		else $error("ack latency source wrong");
	a_tmr_top_zero: assert property (st_q.ack && avs_read && avs_address == `VCC_OFS_TMR
		|-> !avs_readdata[`VCC_B_TMRTOP])
		else $error("timer bit 31 set");
	a_pm_upper_zero: assert property (st_q.ack && avs_read && avs_address == `VCC_OFS_PM
		|-> avs_readdata[`VCC_F_PMRO] == '0)
		else $error("power upper bits set");
	a_debug_zero: assert property (st_q.ack && avs_read && (avs_address == `VCC_OFS_DBG1
		|| avs_address == `VCC_OFS_DBG2 || avs_address == `VCC_OFS_DBG3)
		|-> avs_readdata == `VCC_ZERO32)
		else $error("debug word not zero");
	a_strap_upper_zero: assert property (st_q.ack && avs_read && avs_address == `VCC_OFS_STRAP
		|-> avs_readdata[`VCC_F_STRAPRO] == '0)
		else $error("strap upper bits set");
	a_strap_held: assert property (st_q.strapDone && !nvLoadValid |=> $stable(st_q.strap))
		else $error("strap value moved");
	a_drv_kind_map: assert property (st_q.drv[`VCC_F_DRV0] == `VCC_DRV_MULTI4
		|=> driverKind0 == VCC_KIND_MULTI4)
		else $error("driver mode decode wrong");
	// port one decode and whole-word driver writes
	a_kind1_map: assert property (st_q.drv[`VCC_F_DRV1] == `VCC_DRV_MULTI2
		|=> driverKind1 == VCC_KIND_MULTI2)
		else $error("port one decode wrong");
	a_drv_write: assert property (st_q.ack && avs_write && avs_address == `VCC_OFS_DRV
		&& avs_byteenable == `VCC_BE_ALL |=> st_q.drv == $past(avs_writedata))
		else $error("driver word not written");
	// power parameter keeps only its six writable bits
	a_pm_write: assert property (st_q.ack && avs_write && avs_address == `VCC_OFS_PM
		&& avs_byteenable[0] |=> st_q.pm == $past(avs_writedata[`VCC_F_PM]))
		else $error("power parameter not written");
	// autoload and strap capture; a same-cycle bus write, or for the capture an autoload, would win instead
	a_tmr_autoload: assert property (nvLoadValid && nvLoadAddress == `VCC_OFS_TMR
		&& !busWr |=> st_q.rpl == $past(nvLoadData[`VCC_F_RPL])
		&& st_q.ackLat == $past(nvLoadData[`VCC_F_ACK]))
		else $error("timer autoload lost");
	a_strap_capture: assert property (!st_q.strapDone && st_q.settle == `VCC_SETTLE
		&& strapAgree && !nvLoadValid |=> st_q.strap == $past(strapSync))
		else $error("strap capture wrong");

	c_read_cap: cover property (st_q.ack && avs_read && avs_address == `VCC_OFS_CAP);
	c_write_tmr: cover property (st_q.ack && avs_write && avs_address == `VCC_OFS_TMR);
	c_autoload_strap: cover property (nvLoadValid && nvLoadAddress == `VCC_OFS_STRAP);
	c_user_replay: cover property (st_q.rplEn ##1 replayTimeout == st_q.rpl);
	c_byte_none: cover property (st_q.ack && avs_write && avs_byteenable == `VCC_BE_NONE);
endmodule : vcc_config_bank

// ==== shared/vcc_defs.svh ====
`ifndef VCC_DEFS_SVH
`define VCC_DEFS_SVH
// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define VCC_OFS_CAP 8'ha4
`define VCC_OFS_TST0 8'ha8
`define VCC_OFS_TST1 8'hac
`define VCC_OFS_TMR 8'hb0
`define VCC_OFS_DRV 8'hb4
`define VCC_OFS_PM 8'hb8
`define VCC_OFS_DBG1 8'hbc
`define VCC_OFS_DBG2 8'hc0
`define VCC_OFS_DBG3 8'hc4
`define VCC_OFS_STRAP 8'hc8
// -----------------------------------------------------------------
// constant and reset values
// -----------------------------------------------------------------
`define VCC_CAP_ID 8'h09
`define VCC_CAP_NEXT 8'he0
`define VCC_CAP_LEN 16'h0028
`define VCC_TST0_RST 32'h04001060
`define VCC_TST1_RST 32'h04000271
`define VCC_ZERO32 32'h00000000
`define VCC_RPL_RST 12'h000
`define VCC_ACK_RST 14'h0000
`define VCC_DRV_RST 32'h00000000
`define VCC_PM_RST 6'h00
`define VCC_STRAP_RST 14'h0000
`define VCC_SETTLE 2'h3
`define VCC_BE_ALL 4'hf
`define VCC_BE_NONE 4'h0
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define VCC_F_ID 7:0
`define VCC_F_NEXT 15:8
`define VCC_F_LEN 31:16
`define VCC_F_RPL 11:0
`define VCC_B_RPLEN 12
`define VCC_F_ACK 29:16
`define VCC_B_ACKEN 30
`define VCC_B_TMRTOP 31
`define VCC_F_DRV0 3:0
`define VCC_F_DRV1 7:4
`define VCC_F_PM 5:0
`define VCC_F_PMRO 31:6
`define VCC_F_STRAP 13:0
`define VCC_F_STRAPRO 31:14
// -----------------------------------------------------------------
// driver mode codes
// -----------------------------------------------------------------
`define VCC_DRV_SINGLE 4'h0
`define VCC_DRV_DIFF 4'h1
`define VCC_DRV_MULTI4 4'hb
`define VCC_DRV_MULTI2 4'hf
`endif

// ==== shared/vcc_pkg.sv ====
package vcc_pkg;

	// decoded transmitter driver mode of one serial port
	typedef enum logic [2:0] {
		VCC_KIND_SINGLE,
		VCC_KIND_DIFF,
		VCC_KIND_MULTI4,
		VCC_KIND_MULTI2,
		VCC_KIND_UNDEF
	} vcc_drv_kind_t;

	// whole state of the configuration bank
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [31:0] test0;
		logic [31:0] test1;
		logic [11:0] rpl;
		logic rplEn;
		logic [13:0] ackLat;
		logic ackEn;
		logic [31:0] drv;
		logic [5:0] pm;
		logic [13:0] strap;
		logic strapDone;
		logic [1:0] settle;
		logic [11:0] effRpl;
		logic [13:0] effAck;
		vcc_drv_kind_t kind0;
		vcc_drv_kind_t kind1;
	} vcc_state_t;

endpackage : vcc_pkg

// ==== design/vcc_sync3.sv ====
`timescale 1ns/100ps
module vcc_sync3 #(
	parameter int WIDTH = 14
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// asynchronous pins in
	input wire logic [WIDTH-1:0] asyncIn,
	// synchronised view
	output logic [WIDTH-1:0] syncOut,
	output logic agree
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
	} vcc_sync_state_t;

	vcc_sync_state_t st_q;
	vcc_sync_state_t st_d;

	// shift chain; s1 is only ever read by s2
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = asyncIn;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// a change counts only once stages two and three match
	assign syncOut = st_q.s3;
	assign agree = (st_q.s2 == st_q.s3);
endmodule : vcc_sync3

// ==== design/vcc_drv_decode.sv ====
`timescale 1ns/100ps
`include "vcc_defs.svh"
module vcc_drv_decode
	import vcc_pkg::*;
(
	// raw four-bit mode field
	input wire logic [3:0] code,
	// decoded mode
	output vcc_drv_kind_t kind,
	output logic legal
);
	// codes outside the four documented ones report undefined
	always_comb
	begin
		legal = 1'b1;
		case (code)
			`VCC_DRV_SINGLE: kind = VCC_KIND_SINGLE;
			`VCC_DRV_DIFF: kind = VCC_KIND_DIFF;
			`VCC_DRV_MULTI4: kind = VCC_KIND_MULTI4;
			`VCC_DRV_MULTI2: kind = VCC_KIND_MULTI2;
			default:
			begin
				kind = VCC_KIND_UNDEF;
				legal = 1'b0;
			end
		endcase
	end
endmodule : vcc_drv_decode

// ==== verification/vcc_config_bank_tb.sv ====
`timescale 1ns/100ps
`include "vcc_defs.svh"
module vcc_config_bank_tb
	import vcc_pkg::*;
;
	// ---------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------
	logic clk;
	logic reset_n;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic nvLoadValid;
	logic [7:0] nvLoadAddress;
	logic [31:0] nvLoadData;
	logic lowDrv;
	logic highDrv;
	logic [3:0] txCur;
	logic [3:0] deemph;
	logic [1:0] rxTerm;
	logic [1:0] txTerm;
	logic [11:0] replayTimeout;
	logic [13:0] ackLatency;
	logic [3:0] driverMode0;
	logic [3:0] driverMode1;
	vcc_drv_kind_t driverKind0;
	vcc_drv_kind_t driverKind1;
	logic [5:0] powerParameter;
	logic strapsValid;
	int err_total;
	int tests_run;
	logic [31:0] rd;
	logic [31:0] drvWord;
	logic [3:0] codes [4];
	vcc_drv_kind_t kinds [4];
	logic [7:0] roAddr [5];
	logic [31:0] roExp [5];
	// distinct pattern on every strap group: c8 expects 1969h
	localparam logic [11:0] BI_RPL = 12'h123;
	localparam logic [13:0] BI_ACK = 14'h2abc;
	localparam logic [31:0] STRAP_EXP = 32'h00001969;

	vcc_config_bank u_dut (
		.clk(clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.nvLoadValid(nvLoadValid), .nvLoadAddress(nvLoadAddress), .nvLoadData(nvLoadData),
		.lowDriveStrap(lowDrv), .highDriveStrap(highDrv),
		.transmitCurrentStraps(txCur), .deemphasisStraps(deemph),
		.rxTerminationStraps(rxTerm), .txTerminationStraps(txTerm),
		.builtinReplayTimeout(BI_RPL), .builtinAckLatency(BI_ACK),
		.replayTimeout(replayTimeout), .ackLatency(ackLatency),
		.driverMode0(driverMode0), .driverMode1(driverMode1),
		.driverKind0(driverKind0), .driverKind1(driverKind1),
		.powerParameter(powerParameter), .strapsValid(strapsValid)
	);

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp);
		begin
			tests_run++;
			if (got !== exp)
			begin
				err_total++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask : check

	// one avalon cycle; request held until waitrequest is seen low
	task bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		begin
			@(posedge clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_byteenable <= be;
			avs_write <= wr;
			avs_read <= ~wr;
			@(posedge clk);
			n = 0;
			// no local limit: only the watchdog ends a hung handshake
			while (avs_waitrequest !== 1'b0)
			begin
				@(posedge clk);
				n++;
			end
			rd = avs_readdata;
			check(n, 32'h1);
			avs_write <= 1'b0;
			avs_read <= 1'b0;
		end
	endtask : bus_xfer

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		begin
			bus_xfer(1'b0, a, 32'h0, `VCC_BE_ALL);
			check(rd, exp);
		end
	endtask : rchk

	// one-cycle autoload pulse
	task nv_load(input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			nvLoadValid <= 1'b1;
			nvLoadAddress <= a;
			nvLoadData <= d;
			@(posedge clk);
			nvLoadValid <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : nv_load

	task wrap_up;
		begin
			if (err_total == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask : wrap_up

	// watchdog: the whole sequence needs well under 2000 cycles
	initial
	begin
		#200000;
		check(32'h0, 32'h1);
		wrap_up();
	end

	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial
	begin
		err_total = 0;
		tests_run = 0;
		reset_n = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
		{nvLoadValid, nvLoadAddress, nvLoadData} = '0;
		{lowDrv, highDrv, txCur, deemph, rxTerm, txTerm} = {2'b10, 4'ha, 4'h5, 2'h2, 2'h1};
		codes = '{`VCC_DRV_SINGLE, `VCC_DRV_DIFF, `VCC_DRV_MULTI4, `VCC_DRV_MULTI2};
		kinds = '{VCC_KIND_SINGLE, VCC_KIND_DIFF, VCC_KIND_MULTI4, VCC_KIND_MULTI2};
		roAddr = '{`VCC_OFS_CAP, `VCC_OFS_DBG1, `VCC_OFS_DBG2, `VCC_OFS_DBG3, `VCC_OFS_STRAP};
		roExp = '{{`VCC_CAP_LEN, `VCC_CAP_NEXT, `VCC_CAP_ID}, 32'h0, 32'h0, 32'h0, STRAP_EXP};
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		check({31'h0, strapsValid}, 32'h1);
		// reset values of every register but the debug and strap words
		rchk(`VCC_OFS_CAP, 32'h0028e009);
		rchk(`VCC_OFS_TST0, 32'h04001060);
		rchk(`VCC_OFS_TST1, 32'h04000271);
		rchk(`VCC_OFS_TMR, 32'h0);
		rchk(`VCC_OFS_DRV, 32'h0);
		rchk(`VCC_OFS_PM, 32'h0);
		check({20'h0, replayTimeout}, {20'h0, BI_RPL});
		check({18'h0, ackLatency}, {18'h0, BI_ACK});
		check({29'h0, driverKind0}, {29'h0, VCC_KIND_SINGLE});
		// read-only places ignore writes, then read their fixed value
		for (int i = 0; i < 5; i++)
			bus_xfer(1'b1, roAddr[i], 32'hffffffff, `VCC_BE_ALL);
		for (int i = 0; i < 5; i++)
			rchk(roAddr[i], roExp[i]);
		// test words back to back, then a single byte lane
		bus_xfer(1'b1, `VCC_OFS_TST0, 32'ha5a55a5a, `VCC_BE_ALL);
		bus_xfer(1'b1, `VCC_OFS_TST1, 32'h01234567, `VCC_BE_ALL);
		bus_xfer(1'b1, `VCC_OFS_TST0, 32'hffffffff, 4'h2);
		bus_xfer(1'b1, `VCC_OFS_TST1, 32'hffffffff, `VCC_BE_NONE);
		rchk(`VCC_OFS_TST0, 32'ha5a5ff5a);
		rchk(`VCC_OFS_TST1, 32'h01234567);
		// timer overrides: reserved bits stay zero, enables select user values
		bus_xfer(1'b1, `VCC_OFS_TMR, 32'hffffffff, `VCC_BE_ALL);
		rchk(`VCC_OFS_TMR, 32'h7fff1fff);
		repeat (3) @(posedge clk);
		check({20'h0, replayTimeout}, 32'h00000fff);
		check({18'h0, ackLatency}, 32'h00003fff);
		bus_xfer(1'b1, `VCC_OFS_TMR, 32'h0, 4'h3);
		rchk(`VCC_OFS_TMR, 32'h7fff0000);
		repeat (3) @(posedge clk);
		check({20'h0, replayTimeout}, {20'h0, BI_RPL});
		check({18'h0, ackLatency}, 32'h00003fff);
		bus_xfer(1'b1, `VCC_OFS_TMR, 32'h0, 4'hc);
		repeat (3) @(posedge clk);
		check({18'h0, ackLatency}, {18'h0, BI_ACK});
		// every driver code on both ports, upper bits kept as written
		for (int i = 0; i < 4; i++)
		begin
			drvWord = {8'(i), 16'h5aa5, codes[3 - i], codes[i]};
			bus_xfer(1'b1, `VCC_OFS_DRV, drvWord, `VCC_BE_ALL);
			rchk(`VCC_OFS_DRV, drvWord);
			repeat (3) @(posedge clk);
			check({28'h0, driverMode0}, {28'h0, codes[i]});
			check({28'h0, driverMode1}, {28'h0, codes[3 - i]});
			check({29'h0, driverKind0}, {29'h0, kinds[i]});
			check({29'h0, driverKind1}, {29'h0, kinds[3 - i]});
		end
		// power parameter: only six bits stick
		bus_xfer(1'b1, `VCC_OFS_PM, 32'hffffffff, `VCC_BE_ALL);
		rchk(`VCC_OFS_PM, 32'h0000003f);
		check({26'h0, powerParameter}, 32'h0000003f);
		// late strap changes must not reach the reflection word
		@(posedge clk);
		{lowDrv, highDrv, txCur, deemph, rxTerm, txTerm} <= 14'h0ff5;
		repeat (10) @(posedge clk);
		rchk(`VCC_OFS_STRAP, STRAP_EXP);
		// autoload replaces defaults; a test word is not a target
		nv_load(`VCC_OFS_TMR, 32'h4abc1456);
		nv_load(`VCC_OFS_DRV, 32'h000000b1);
		nv_load(`VCC_OFS_PM, 32'h0000002a);
		nv_load(`VCC_OFS_STRAP, 32'h00002aaa);
		nv_load(`VCC_OFS_TST1, 32'h0);
		rchk(`VCC_OFS_TMR, 32'h4abc1456);
		check({20'h0, replayTimeout}, 32'h00000456);
		check({18'h0, ackLatency}, 32'h00000abc);
		rchk(`VCC_OFS_DRV, 32'h000000b1);
		check({28'h0, driverMode1}, 32'h0000000b);
		rchk(`VCC_OFS_PM, 32'h0000002a);
		rchk(`VCC_OFS_STRAP, 32'h00002aaa);
		rchk(`VCC_OFS_TST1, 32'h01234567);
		// unmapped offset reads zero and swallows writes
		bus_xfer(1'b1, 8'hd0, 32'hffffffff, `VCC_BE_ALL);
		rchk(8'hd0, 32'h0);
		wrap_up();
	end
endmodule : vcc_config_bank_tb
